//--- src/thermo_cmd_decoder.sv
// Two-wire command decoder of a thermometer with nonvolatile memory.
`include "thermo_map.svh"
// How it works
// - Memory code: next byte loads address pointer.
// - Config code, write: mode bit of next byte stored.
// - Config code, read: config byte returned.
// - Temperature code: two result bytes sent.
// - Begin code starts conversion, no data.
// - Single mode: one conversion, then idle.
// - Continuous mode: conversions repeat until halted.
// - Halt finishes current conversion, then idle.
// - No acknowledge during nonvolatile write cycle.
// - Config write sequence; 00h means continuous.
// - Acknowledge address, command and data bytes.
// - Temperature high byte first, then low.
// - Config top bit shows conversion done.
// - Config low bit selects mode, reset 0.
// - 13-bit result, three low bits padded.
// - Address is code, pins, direction bit.
module thermo_cmd_decoder
    import thermo_pkg::*;
#(
    parameter int NV_WAIT_CYCLES = `NV_WAIT_CYC,
    parameter int CONV_CYCLES = `CONV_CYC,
    parameter logic [3:0] DEV_CODE = `DEV_CODE_DEFAULT // Arbitrary value.
)(
    input wire logic mclk, // System clock, 20 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable, freezes all state when low.
    input wire logic sclPin, // Serial clock from the master.
    input wire logic sdaIn, // Serial data line level.
    output logic sdaOut, // Serial data drive value, always low.
    output logic sdaOe, // High while this end pulls the data line.
    input wire logic [2:0] addrPins, // Address select pins.
    input wire logic [`TEMP_BITS-1:0] tempSense, // Sensor value.
    output logic nvBusy, // High during a nonvolatile write cycle.
    output logic convDone // Conversion completion flag.
);
    localparam int NW = $clog2(NV_WAIT_CYCLES + 1);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    bus_evt_t evt; // Bus events.
    conv_ctl_t convCtl; // Converter control.
    logic [`TEMP_BITS-1:0] tempResult; // Completed result.
    link_state_t stReg; // Link state.
    byte_kind_t kindReg; // Meaning of the byte being received.
    logic [3:0] bitCnt; // Bits moved in the current byte.
    logic [7:0] shReg; // Shift register, both directions.
    logic rwReg; // Direction bit of the last address.
    logic sdaOeReg; // Registered data line pull.
    logic [7:0] cmdReg; // Last command byte.
    logic [7:0] ptrReg; // Memory address pointer.
    logic ptrLoaded; // Pointer byte already received.
    logic txIdx; // Which temperature byte is next.
    logic cfgModeReg; // Single conversion select bit.
    logic beginReg; // Begin pulse to the converter.
    logic haltReg; // Halt pulse to the converter.
    logic nvPendReg; // A write waits for STOP to commit.
    logic nvBusyReg; // Write cycle running.
    logic [NW-1:0] nvCntReg; // Write cycle cycles left.
    logic [2:0] addrMeta; // Pin synchroniser, first stage.
    logic [2:0] addrSync; // Pin synchroniser, second stage.
    logic [7:0] memArr [256]; // Nonvolatile array image.

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    bus_sampler uSampler (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .sclPin(sclPin),
        .sdaPin(sdaIn),
        .evt(evt)
    );

    conv_engine #(.CONV_CYCLES(CONV_CYCLES)) uConv (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .ctl(convCtl),
        .tempSense(tempSense),
        .tempResult(tempResult),
        .convDone(convDone)
    );

    // The address pins come from outside, so they are synchronised too.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addrMeta <= 3'h0;
            addrSync <= 3'h0;
        end else if (ce) begin
            addrMeta <= addrPins;
            addrSync <= addrMeta;
        end
    end

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    wire byteDone = ce && (stReg == S_RX) && evt.sclFall && (bitCnt == 4'h8);
    wire addrHit = (shReg[7:1] == {DEV_CODE, addrSync});
    wire addrAck = addrHit && !nvBusyReg;
    wire isAddr = byteDone && (kindReg == B_ADDR);
    wire isCmd = byteDone && (kindReg == B_CMD);
    wire isData = byteDone && (kindReg == B_DATA);
    wire cmdMem = (cmdReg == `CMD_MEM_ACCESS);
    wire cmdCfg = (cmdReg == `CMD_CFG_ACCESS);
    wire cmdTemp = (cmdReg == `CMD_TEMP_READ);
    wire [7:0] cfgByte = {convDone, `CFG_FIXED_BITS, cfgModeReg};
    wire [7:0] tempHi = tempResult[12:5];
    wire [7:0] tempLo = {tempResult[4:0], `TEMP_LSB_PAD};
    wire [7:0] tempByte = txIdx ? tempLo : tempHi;
    wire [7:0] txByte = cmdTemp ? tempByte : (cmdCfg ? cfgByte : memArr[ptrReg]);
    wire ackEnd = ce && (stReg == S_ACK) && evt.sclFall;
    wire txLoad = (ackEnd && rwReg) || (ce && (stReg == S_MACK) && evt.sclFall);
    wire [7:0] ptrPage = {ptrReg[7:`PAGE_BITS], ptrReg[`PAGE_BITS-1:0] + 3'h1};
    wire nvKick = ce && evt.stop && nvPendReg;

    assign convCtl = '{beginPulse: beginReg, haltPulse: haltReg,
                       singleConversionSelect: cfgModeReg};
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOeReg;
    assign nvBusy = nvBusyReg;

    // ---------------------------------------------------------------
    // Link state machine
    // ---------------------------------------------------------------
    // START wins over every state, so a repeated START always re-arms the decoder.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stReg <= S_IDLE;
            kindReg <= B_ADDR;
            bitCnt <= 4'h0;
            shReg <= 8'h00;
            rwReg <= 1'b0;
            sdaOeReg <= 1'b0;
        end else if (ce) begin
            if (evt.start) begin
                stReg <= S_RX;
                kindReg <= B_ADDR;
                bitCnt <= 4'h0;
                sdaOeReg <= 1'b0;
            end else if (evt.stop) begin
                stReg <= S_IDLE;
                sdaOeReg <= 1'b0;
            end else begin
                unique case (stReg)
                    S_IDLE: begin
                        sdaOeReg <= 1'b0;
                    end
                    S_RX: begin
                        if (evt.sclRise) begin
                            shReg <= {shReg[6:0], evt.sda};
                            bitCnt <= bitCnt + 4'h1;
                        end else if (byteDone) begin
                            // Foreign or busy address: stay off the line.
                            if (kindReg != B_ADDR || addrAck) begin
                                stReg <= S_ACK;
                                sdaOeReg <= 1'b1;
                            end else begin
                                stReg <= S_IDLE;
                            end
                            if (kindReg == B_ADDR) begin
                                rwReg <= shReg[0];
                            end
                        end
                    end
                    S_ACK: begin
                        if (evt.sclFall) begin
                            bitCnt <= 4'h0;
                            kindReg <= (kindReg == B_ADDR) ? B_CMD : B_DATA;
                            if (rwReg) begin
                                stReg <= S_TX;
                                shReg <= txByte;
                                sdaOeReg <= ~txByte[7];
                            end else begin
                                stReg <= S_RX;
                                sdaOeReg <= 1'b0;
                            end
                        end
                    end
                    S_TX: begin
                        if (evt.sclFall) begin
                            if (bitCnt == 4'h7) begin
                                stReg <= S_MACK;
                                sdaOeReg <= 1'b0;
                            end else begin
                                shReg <= {shReg[6:0], 1'b0};
                                sdaOeReg <= ~shReg[6];
                                bitCnt <= bitCnt + 4'h1;
                            end
                        end
                    end
                    S_MACK: begin
                        // A released line is a not-acknowledge and ends the read.
                        if (evt.sclRise && evt.sda) begin
                            stReg <= S_IDLE;
                        end else if (evt.sclFall) begin
                            stReg <= S_TX;
                            bitCnt <= 4'h0;
                            shReg <= txByte;
                            sdaOeReg <= ~txByte[7];
                        end
                    end
                    default: begin
                        stReg <= S_IDLE;
                        sdaOeReg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Command and data effects
    // ---------------------------------------------------------------
    // Set beats clear: a byte can not end in the cycle of a START or STOP.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmdReg <= 8'h00;
            ptrReg <= 8'h00;
            ptrLoaded <= 1'b0;
            txIdx <= 1'b0;
            cfgModeReg <= `CFG_MODE_RESET;
            beginReg <= 1'b0;
            haltReg <= 1'b0;
            nvPendReg <= 1'b0;
        end else if (ce) begin
            beginReg <= isCmd && (shReg == `CMD_CONV_BEGIN);
            haltReg <= isCmd && (shReg == `CMD_CONV_HALT);
            if (isCmd) begin
                cmdReg <= shReg;
                ptrLoaded <= 1'b0;
                txIdx <= 1'b0;
            end else if (isData && cmdMem && !ptrLoaded) begin
                ptrReg <= shReg;
                ptrLoaded <= 1'b1;
            end else if (isData && cmdMem) begin
                ptrReg <= ptrPage; // Page roll-over inside eight bytes.
                nvPendReg <= 1'b1;
            end else if (isData && cmdCfg) begin
                cfgModeReg <= shReg[`CFG_MODE_BIT];
                nvPendReg <= 1'b1;
            end else if (txLoad && cmdTemp) begin
                txIdx <= ~txIdx;
            end else if (txLoad && cmdMem) begin
                ptrReg <= ptrReg + 8'h01;
            end else if (evt.start || evt.stop) begin
                // A repeated START abandons a pending write cycle.
                nvPendReg <= 1'b0;
            end
        end
    end

    // The array has no reset; only written bytes are meaningful.
    always_ff @(posedge mclk) begin
        if (isData && cmdMem && ptrLoaded) begin
            memArr[ptrReg] <= shReg;
        end
    end

    // ---------------------------------------------------------------
    // Nonvolatile write cycle timer
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nvBusyReg <= 1'b0;
            nvCntReg <= '0;
        end else if (ce) begin
            if (nvKick) begin
                nvBusyReg <= 1'b1;
                nvCntReg <= NW'(NV_WAIT_CYCLES - 1);
            end else if (nvBusyReg && nvCntReg == '0) begin
                nvBusyReg <= 1'b0;
            end else if (nvBusyReg) begin
                nvCntReg <= nvCntReg - 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_busy_hold;
        nvBusyReg [*8];
    endsequence
    property p_busy_span;
        nvKick |=> s_busy_hold;
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("write cycle too short");
    property p_busy_nack;
        isAddr && nvBusyReg |=> !sdaOeReg && stReg == S_IDLE;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");
    property p_cmd_ack;
        isCmd && !evt.start && !evt.stop |=> sdaOeReg && stReg == S_ACK;
    endproperty
    a_cmd_ack: assert property (p_cmd_ack) else $error("command not acked");
    property p_ptr_load;
        isData && cmdMem && !ptrLoaded |=> ptrReg == $past(shReg);
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
    property p_cfg_write;
        isData && cmdCfg |=> cfgModeReg == $past(shReg[0]) ##1 nvPendReg;
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config not stored");
    property p_cfg_read;
        txLoad && cmdCfg && !evt.start && !evt.stop |=> shReg == $past(cfgByte);
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");
    property p_temp_msb;
        txLoad && cmdTemp && !txIdx && !evt.start && !evt.stop
            |=> shReg == $past(tempResult[12:5]) && txIdx;
    endproperty
    a_temp_msb: assert property (p_temp_msb) else $error("temperature order wrong");
    property p_begin;
        isCmd && shReg == `CMD_CONV_BEGIN |=> beginReg ##1 !beginReg;
    endproperty
    a_begin: assert property (p_begin) else $error("begin pulse missing");
endmodule

//--- src/thermo_map.svh
// Command codes, field positions, reset values and timing counts of the thermometer decoder.
`ifndef THERMO_MAP_SVH
`define THERMO_MAP_SVH
// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define CMD_MEM_ACCESS 8'h17
`define CMD_CFG_ACCESS 8'hac
`define CMD_TEMP_READ 8'haa
`define CMD_CONV_BEGIN 8'hee
`define CMD_CONV_HALT 8'h22
// ---------------------------------------------------------------
// Configuration byte layout, reset values, result and page widths
// ---------------------------------------------------------------
`define CFG_DONE_BIT 7
`define CFG_MODE_BIT 0
`define CFG_FIXED_BITS 6'h25
`define CFG_MODE_RESET 1'b0
`define DEV_CODE_DEFAULT 4'h5
`define TEMP_BITS 13
`define TEMP_LSB_PAD 3'h0
`define PAGE_BITS 3
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define NV_WAIT_NS 10000000
`define NV_WAIT_CYC (`NV_WAIT_NS / `CLK_PERIOD_NS)
`define CONV_TIME_NS 1000000000
`define CONV_CYC (`CONV_TIME_NS / `CLK_PERIOD_NS)
`endif

//--- src/thermo_pkg.sv
// Types shared by the thermometer decoder and its helpers.
package thermo_pkg;
    // Bus events seen by the sampler, one cycle each, and the data level.
    typedef struct packed {
        logic sclRise;
        logic sclFall;
        logic start;
        logic stop;
        logic sda;
    } bus_evt_t;
    // Converter control pulses and mode.
    typedef struct packed {
        logic beginPulse;
        logic haltPulse;
        logic singleConversionSelect;
    } conv_ctl_t;
    typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} link_state_t;
    typedef enum logic [1:0] {B_ADDR, B_CMD, B_DATA} byte_kind_t;
    typedef enum logic {C_IDLE, C_RUN} conv_state_t;
endpackage

//--- src/bus_sampler.sv
// Synchroniser and START, STOP and clock edge detector for the two-wire bus.
module bus_sampler
    import thermo_pkg::*;
(
    input wire logic mclk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable, freezes state when low.
    input wire logic sclPin, // Serial clock pin.
    input wire logic sdaPin, // Serial data pin level.
    output bus_evt_t evt // Decoded bus events.
);
    // ---------------------------------------------------------------
    // Two flip-flop synchroniser plus one history stage
    // ---------------------------------------------------------------
    logic [1:0] metaReg; // First stage, read only by the second.
    logic [1:0] syncReg; // Settled {scl, sda}.
    logic [1:0] prevReg; // Settled value one cycle earlier.

    // The first stage feeds nothing but the second, so no metastable value leaks.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            metaReg <= 2'h3;
            syncReg <= 2'h3;
            prevReg <= 2'h3;
        end else if (ce) begin
            metaReg <= {sclPin, sdaPin};
            syncReg <= metaReg;
            prevReg <= syncReg;
        end
    end

    // ---------------------------------------------------------------
    // Event decode
    // ---------------------------------------------------------------
    // A data change while the clock is high is a START or a STOP.
    // One driver for the whole struct keeps every member on a single assignment.
    assign evt = '{sclRise: syncReg[1] & ~prevReg[1],
                   sclFall: ~syncReg[1] & prevReg[1],
                   start: syncReg[1] & prevReg[1] & ~syncReg[0] & prevReg[0],
                   stop: syncReg[1] & prevReg[1] & syncReg[0] & ~prevReg[0],
                   sda: syncReg[0]};
endmodule

//--- src/conv_engine.sv
// Conversion sequencer with single and continuous modes and a result register.
`include "thermo_map.svh"
module conv_engine
    import thermo_pkg::*;
#(
    parameter int CONV_CYCLES = `CONV_CYC
)(
    input wire logic mclk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable.
    input conv_ctl_t ctl, // Begin and halt pulses, mode.
    input wire logic [`TEMP_BITS-1:0] tempSense, // Live sensor value.
    output logic [`TEMP_BITS-1:0] tempResult, // Last completed result.
    output logic convDone // High once a conversion has finished.
);
    localparam int CW = $clog2(CONV_CYCLES + 1);
    conv_state_t stReg; // Sequencer state.
    logic [CW-1:0] cntReg; // Cycles into the current conversion.
    logic haltReg; // Halt seen, stop at the end of this conversion.
    wire finish = (stReg == C_RUN) && (cntReg == CW'(CONV_CYCLES - 1));
    wire stopNow = ctl.singleConversionSelect | haltReg | ctl.haltPulse;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    // A halt never cuts a conversion short; the result stays whole.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stReg <= C_IDLE;
            cntReg <= '0;
            haltReg <= 1'b0;
            convDone <= 1'b0;
            tempResult <= '0;
        end else if (ce) begin
            unique case (stReg)
                C_IDLE: begin
                    if (ctl.beginPulse) begin
                        stReg <= C_RUN;
                        cntReg <= '0;
                        haltReg <= 1'b0;
                        convDone <= 1'b0;
                    end
                end
                C_RUN: begin
                    if (ctl.haltPulse) begin
                        haltReg <= 1'b1;
                    end
                    if (finish) begin
                        tempResult <= tempSense;
                        convDone <= 1'b1;
                        cntReg <= '0;
                        if (stopNow) begin
                            stReg <= C_IDLE;
                        end
                    end else begin
                        cntReg <= cntReg + 1'b1;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_single_idle;
        ce && finish && ctl.singleConversionSelect |=> stReg == C_IDLE;
    endproperty
    a_single_idle: assert property (p_single_idle) else $error("single mode kept running");
    property p_cont_rerun;
        ce && finish && !stopNow |=> stReg == C_RUN && cntReg == '0;
    endproperty
    a_cont_rerun: assert property (p_cont_rerun) else $error("continuous mode stopped");
    property p_result_hold;
        !(ce && finish) |=> $stable(tempResult);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed early");
endmodule

//--- test/bus_master_model.sv
// Two-wire bus master model, paced on the falling edge of the system clock.
module bus_master_model (
    input wire logic mclk, // Pacing clock.
    input wire logic sdaWire, // Resolved data line.
    output logic scl = 1'b1, // Bus clock, still between frames.
    output logic mLow = 1'b0 // High while pulling data low.
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Six low cycles keep the synchronised sampler well ahead of each edge.
    task automatic bit_x(input logic b, output logic r);
        tick(1);
        mLow = ~b;
        tick(5);
        scl = 1'b1;
        tick(2);
        r = sdaWire;
        scl = 1'b0;
    endtask
    // A START, or a repeated START, made while the clock is high.
    task automatic start_c;
        mLow = 1'b0;
        tick(6);
        scl = 1'b1;
        tick(4);
        mLow = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic stop_c;
        mLow = 1'b1;
        tick(6);
        scl = 1'b1;
        tick(4);
        mLow = 1'b0;
        tick(6);
    endtask
    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    task automatic byte_r(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(~mack, r);
    endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the thermometer command decoder.
`include "thermo_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst_n, scl, mLow, sdaOut, sdaOe, nvBusy, convDone; // Bench nets.
    logic [2:0] addrPins = 3'h3; // Address pins.
    logic ceIn = 1'b1; // Clock enable.
    logic [`TEMP_BITS-1:0] tempSense = 13'h1a5b; // Sensor value.
    logic [7:0] hi, lo; // Bytes read back.
    int err_total, checked; // Counters.
    wire logic sdaWire = ~((sdaOe & ~sdaOut) | mLow); // Pulled-up wire.
    thermo_cmd_decoder #(.NV_WAIT_CYCLES(200), .CONV_CYCLES(400)) DUT (.mclk(mclk),
        .rst_n(rst_n), .ce(ceIn), .sclPin(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .addrPins(addrPins), .tempSense(tempSense), .nvBusy(nvBusy),
        .convDone(convDone));
    bus_master_model M (.mclk(mclk), .sdaWire(sdaWire), .scl(scl), .mLow(mLow));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic test_done;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Bounded wait for the busy or done flag; running out ends the run.
    task automatic wt(input bit conv, input logic v);
        int i;
        for (i = 0; i < 1000 && (conv ? convDone : nvBusy) !== v; i++)
            M.tick(1);
        if (i == 1000) begin
            err_total++;
            test_done();
        end
    endtask
    // START, address, command and n argument bytes, each acknowledged.
    task automatic head(input logic [7:0] cmd, input logic [15:0] d, input int n);
        logic a;
        M.start_c();
        M.byte_w({`DEV_CODE_DEFAULT, addrPins, 1'b0}, a);
        chk("addr ack", 8'h1, {7'h0, a});
        M.byte_w(cmd, a);
        chk("cmd ack", 8'h1, {7'h0, a});
        for (int i = n - 1; i >= 0; i--) begin
            M.byte_w(d[i*8 +: 8], a);
            chk("data ack", 8'h1, {7'h0, a});
        end
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
        head(cmd, d, n);
        M.stop_c();
    endtask
    // Two bytes are read; the master refuses the second.
    task automatic rd(input logic [7:0] cmd, input logic [7:0] arg, input int n);
        logic a;
        head(cmd, {8'h0, arg}, n);
        M.start_c();
        M.byte_w({`DEV_CODE_DEFAULT, addrPins, 1'b1}, a);
        chk("read ack", 8'h1, {7'h0, a});
        M.byte_r(1'b1, hi);
        M.byte_r(1'b0, lo);
        M.stop_c();
    endtask
    task automatic tchk(input logic [`TEMP_BITS-1:0] t);
        rd(`CMD_TEMP_READ, 8'h0, 0);
        chk("temp hi", t[12:5], hi);
        chk("temp lo", {t[4:0], `TEMP_LSB_PAD}, lo);
    endtask
    // Mode write, refusal while busy, read-back.
    task automatic s_cfg;
        logic a;
        rd(`CMD_CFG_ACCESS, 8'h0, 0);
        chk("cfg reset", {1'b0, `CFG_FIXED_BITS, `CFG_MODE_RESET}, hi);
        wr(`CMD_CFG_ACCESS, 16'h1, 1);
        M.start_c();
        M.byte_w({`DEV_CODE_DEFAULT, addrPins, 1'b0}, a);
        chk("busy ack", 8'h0, {7'h0, a});
        M.stop_c();
        // A low clock enable must hold the write timer where it stands.
        ceIn = 1'b0;
        M.tick(300);
        chk("ce freeze", 8'h1, {7'h0, nvBusy});
        ceIn = 1'b1;
        wt(0, 0);
        rd(`CMD_CFG_ACCESS, 8'h0, 0);
        chk("cfg single", {1'b0, `CFG_FIXED_BITS, 1'b1}, hi);
    endtask
    // One begin, one result; later sensor changes must not reach it.
    task automatic s_single;
        wr(`CMD_CONV_BEGIN, 16'h0, 0);
        chk("done low", 8'h0, {7'h0, convDone});
        wt(1, 1);
        tempSense = 13'h0f0f;
        M.tick(900);
        tchk(13'h1a5b);
        rd(`CMD_CFG_ACCESS, 8'h0, 0);
        chk("cfg done", {1'b1, `CFG_FIXED_BITS, 1'b1}, hi);
    endtask
    // Continuous mode follows the sensor until halted.
    task automatic s_cont;
        tempSense = 13'h1555;
        wr(`CMD_CFG_ACCESS, 16'h0, 1);
        wt(0, 0);
        wr(`CMD_CONV_BEGIN, 16'h0, 0);
        chk("done cleared", 8'h0, {7'h0, convDone});
        M.tick(900);
        tchk(13'h1555);
        tempSense = 13'h0aaa;
        M.tick(900);
        tchk(13'h0aaa);
        wr(`CMD_CONV_HALT, 16'h0, 0);
        M.tick(500);
        tempSense = 13'h1fff;
        M.tick(900);
        tchk(13'h0aaa);
    endtask
    task automatic s_mem;
        logic a;
        addrPins = 3'h6;
        wt(0, 0);
        wr(`CMD_MEM_ACCESS, 16'h429c, 2);
        wt(0, 0);
        wr(`CMD_MEM_ACCESS, 16'h4355, 2);
        wt(0, 0);
        rd(`CMD_MEM_ACCESS, 8'h42, 1);
        chk("mem byte", 8'h9c, hi);
        chk("mem next", 8'h55, lo);
        M.start_c();
        M.byte_w({`DEV_CODE_DEFAULT, ~addrPins, 1'b0}, a);
        chk("foreign ack", 8'h0, {7'h0, a});
        M.stop_c();
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        M.tick(4);
        s_cfg();
        s_single();
        s_cont();
        s_mem();
        test_done();
    end
endmodule
